// ==== dahr_pkg.sv ====
package dahr_pkg;

  localparam int CLK_PERIOD_NS = 100;

  // Row address hold after the bank row strobe falls, per automatic mode.
  localparam int ROW_HOLD_NS_HIDDEN = 30;
  localparam int ROW_HOLD_NS_FAST   = 20;
  localparam int ROW_HOLD_CYC_HIDDEN =
    ((ROW_HOLD_NS_HIDDEN + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
    ((ROW_HOLD_NS_HIDDEN + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int ROW_HOLD_CYC_FAST =
    ((ROW_HOLD_NS_FAST + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
    ((ROW_HOLD_NS_FAST + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Write request lead before the column strobe, kept by the host.
  localparam int WRITE_LEAD_NS = 30;

  localparam int ADDR_W = 9;

  // Mode pin encodings, most significant pin first.
  localparam logic [2:0] MODE_FORCED_REFRESH = 3'h1;
  localparam logic [2:0] MODE_HIDDEN_AUTO    = 3'h5;
  localparam logic [2:0] MODE_FAST_AUTO      = 3'h6;
  localparam logic [2:0] MODE_SET_EOC        = 3'h7;

  localparam logic [8:0] EOC_127 = 9'h07F;
  localparam logic [8:0] EOC_255 = 9'h0FF;
  localparam logic [8:0] EOC_511 = 9'h1FF;
  localparam logic [1:0] EOC_SEL_RESET = 2'h3;

  typedef enum logic [1:0] {
    DAHR_IDLE,
    DAHR_ROW,
    DAHR_COL,
    DAHR_CAS
  } dahr_state_e;

endpackage

// ==== dahr_ctrl.sv ====
// Functional notes
// RQ1: Hidden-refresh auto mode derives bank strobe, row/column switch, column strobe from row strobe.
// RQ2: Row address held at least 30 ns after bank strobe falls, then column, then strobe.
// RQ3: Bank strobe follows row strobe input about one cycle later with row address valid.
// RQ4: Host lowers write request at least 30 ns before column strobe falls.
// RQ5: Hidden mode uses row/column pin as refresh clock, column strobe pin as generator clock.
// RQ6: Rising refresh period clock sets the internal refresh request flag.
// RQ7: Host keeps refresh period clock period below 16 us.
// RQ8: Refresh clock high, request pending, chip deselected: counter out, all banks follow strobe.
// RQ9: Hidden refresh clears request, blocks until next rising edge, completes past falling edge.
// RQ10: Request still set at refresh clock fall drives refresh flag pin low.
// RQ11: Forced refresh runs only after host drops refresh control, then clears request.
// RQ12: Chip select high again after hidden refresh deselects: controls high, address floats.
// RQ13: Host keeps row strobe high for the gap after lowering chip select.
// RQ14: Latched bank select bits zero to three enable bank strobes zero to three.
// RQ15: Fast auto mode works like hidden mode with a 20 ns row hold.
// RQ16: Fast mode ignores refresh clock; low column strobe input extends the column strobe.
// RQ17: Host keeps column strobe input high when no extended strobe is wanted.
// RQ18: Fast mode has no refresh request flag.
// RQ19: Set-count mode latches bank bits: equal 127, 01 gives 255, 10 gives 511.
// RQ20: Terminal count resets to 127.
// RQ21: Refresh flag pin goes low whenever counter equals the terminal count.
// RQ22: Mode is the three mode pins as binary; top pin is active-low refresh control.
`timescale 1ns/1ps
`default_nettype none
module dahr_ctrl
  import dahr_pkg::*;
#(
  parameter int AW = ADDR_W
) (
  input  wire logic          clock_in,
  input  wire logic          srst_in,
  input  wire logic [2:0]    mode_in,
  input  wire logic [AW-1:0] row_addr_in,
  input  wire logic [AW-1:0] col_addr_in,
  input  wire logic          bank_sel_hi_in,
  input  wire logic          bank_sel_lo_in,
  input  wire logic          address_latch_strobe_in,
  input  wire logic          chip_select_n_in,
  input  wire logic          row_strobe_in,
  input  wire logic          col_strobe_in,
  input  wire logic          write_request_in,
  input  wire logic          refresh_period_clock_in,
  output logic [AW-1:0]      mux_address_out,
  output logic               mux_address_oe_out,
  output logic [3:0]         bank_row_strobe_n_out,
  output logic               col_strobe_n_out,
  output logic               write_strobe_n_out,
  output logic               ctrl_oe_out,
  output logic               refresh_flag_pin_out,
  output logic               refresh_flag_pin_oe_out
);

  logic [AW-1:0] row_latch;
  logic [AW-1:0] col_latch;
  logic [1:0]    bank_latch;
  logic [1:0]    eoc_sel;
  logic [AW-1:0] refresh_count;
  logic [AW-1:0] eoc_value;
  logic          refresh_request;
  logic          refresh_period_clock_prev;
  logic          strobe_prev;
  logic          hidden_active;
  logic          forced_active;
  logic          hidden_done;
  logic          deselected;
  logic          force_ask;
  dahr_state_e   state;
  logic [3:0]    hold_cnt;
  logic [3:0]    hold_need;

  logic mode_hidden;
  logic mode_fast;
  logic mode_eoc;
  logic mode_forced;
  logic refresh_ctrl_n;
  logic refresh_period_clock_rise;
  logic refresh_period_clock_fall;
  logic strobe_low;
  logic hidden_start;
  logic forced_start;
  logic refresh_end;

  always_comb begin
    refresh_ctrl_n = mode_in[2]; // see RQ22
    mode_hidden    = (mode_in == MODE_HIDDEN_AUTO); // see RQ22
    mode_fast      = (mode_in == MODE_FAST_AUTO);
    mode_eoc       = (mode_in == MODE_SET_EOC);
    mode_forced    = (mode_in == MODE_FORCED_REFRESH) && !refresh_ctrl_n;
    refresh_period_clock_rise      = mode_hidden && refresh_period_clock_in && !refresh_period_clock_prev; // see RQ5
    refresh_period_clock_fall      = mode_hidden && !refresh_period_clock_in && refresh_period_clock_prev;
    strobe_low     = !row_strobe_in;
    // Chip deselected while the refresh clock is high and a request is pending turns a foreign strobe into a refresh.
    hidden_start   = mode_hidden && refresh_period_clock_in && refresh_request && chip_select_n_in &&
                     strobe_low && strobe_prev && !hidden_active; // see RQ8
    forced_start   = mode_forced && refresh_request && !forced_active && !hidden_active; // see RQ11
    refresh_end    = (hidden_active || forced_active) && !strobe_low && !strobe_prev;
    hold_need      = mode_fast ? 4'(ROW_HOLD_CYC_FAST) : 4'(ROW_HOLD_CYC_HIDDEN); // see RQ15
    unique case (eoc_sel) // see RQ19
      2'h1:    eoc_value = EOC_255;
      2'h2:    eoc_value = EOC_511;
      default: eoc_value = EOC_127;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      refresh_period_clock_prev   <= 1'b0;
      strobe_prev <= 1'b0;
    end else begin
      refresh_period_clock_prev   <= refresh_period_clock_in;
      strobe_prev <= strobe_low;
    end
  end

  // Address and bank latches are transparent while the strobe is high, except in set-count mode, and hold on its fall.
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      row_latch  <= '0;
      col_latch  <= '0;
      bank_latch <= 2'h0;
    end else if (address_latch_strobe_in && !mode_eoc) begin
      row_latch  <= row_addr_in;
      col_latch  <= col_addr_in;
      bank_latch <= {bank_sel_hi_in, bank_sel_lo_in}; // see RQ14
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      eoc_sel <= EOC_SEL_RESET; // see RQ20
    end else if (mode_eoc && address_latch_strobe_in) begin
      eoc_sel <= {bank_sel_hi_in, bank_sel_lo_in}; // see RQ19
    end
  end

  // Set wins over the clear: a rising edge in the clearing cycle still requests.
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      refresh_request <= 1'b0;
    end else if (mode_fast) begin
      refresh_request <= 1'b0; // see RQ18
    end else if (refresh_period_clock_rise) begin
      refresh_request <= 1'b1; // see RQ6
    end else if (hidden_start || forced_start) begin
      refresh_request <= 1'b0; // see RQ9 RQ11
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      force_ask <= 1'b0;
    end else if (refresh_period_clock_fall && refresh_request && !hidden_start) begin
      force_ask <= 1'b1; // see RQ10
    end else if (forced_start || refresh_period_clock_rise || mode_fast) begin
      force_ask <= 1'b0;
    end
  end

  // A hidden refresh ends only with the strobe, never with the refresh clock; a forced one also ends when refresh control goes high.
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      hidden_active <= 1'b0;
      forced_active <= 1'b0;
    end else begin
      if (hidden_start) begin
        hidden_active <= 1'b1;
      end else if (refresh_end) begin
        hidden_active <= 1'b0; // see RQ9
      end
      if (forced_start) begin
        forced_active <= 1'b1;
      end else if (forced_active && (refresh_end || refresh_ctrl_n)) begin
        forced_active <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      refresh_count <= '0;
    end else if ((hidden_active || forced_active) && refresh_end) begin
      refresh_count <= (refresh_count == eoc_value) ? '0 : refresh_count + 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      hidden_done <= 1'b0;
      deselected  <= 1'b0;
    end else begin
      if (hidden_start) begin
        hidden_done <= 1'b1;
      end else if (refresh_period_clock_fall || !mode_hidden) begin
        hidden_done <= 1'b0;
      end
      if (!chip_select_n_in || !mode_hidden) begin
        deselected <= 1'b0;
      end else if (hidden_done && !hidden_active && !hidden_start && strobe_low == 1'b0 &&
                   refresh_period_clock_in) begin
        deselected <= 1'b1; // see RQ12
      end
    end
  end

  // Access sequence: row address, bank strobe, row hold, column address, then column strobe.
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      state    <= DAHR_IDLE;
      hold_cnt <= 4'h0;
    end else begin
      unique case (state)
        DAHR_IDLE: begin
          if ((mode_hidden || mode_fast) && strobe_low && !chip_select_n_in && !hidden_active) begin
            state    <= DAHR_ROW; // see RQ1 RQ3
            hold_cnt <= 4'h0;
          end
        end
        DAHR_ROW: begin
          if (!strobe_low) begin
            state <= DAHR_IDLE;
          end else if (hold_cnt + 4'h1 >= hold_need) begin
            state <= DAHR_COL; // see RQ2 RQ15
          end else begin
            hold_cnt <= hold_cnt + 4'h1;
          end
        end
        DAHR_COL: begin
          state <= strobe_low ? DAHR_CAS : DAHR_IDLE; // see RQ2
        end
        DAHR_CAS: begin
          // Fast mode may stretch the column strobe past the bank strobe.
          if (!strobe_low && !(mode_fast && !col_strobe_in)) begin
            state <= DAHR_IDLE; // see RQ16
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      bank_row_strobe_n_out <= 4'hF;
      col_strobe_n_out      <= 1'b1;
      write_strobe_n_out    <= 1'b1;
      mux_address_out       <= '0;
      mux_address_oe_out    <= 1'b0;
      ctrl_oe_out           <= 1'b0;
    end else begin
      write_strobe_n_out <= write_request_in;
      ctrl_oe_out        <= !deselected;
      mux_address_oe_out <= !deselected; // see RQ12
      if (hidden_active || forced_active || hidden_start || forced_start) begin
        mux_address_out       <= refresh_count; // see RQ8
        bank_row_strobe_n_out <= {4{!(strobe_low || forced_active || forced_start)}}; // see RQ8 RQ11
        col_strobe_n_out      <= 1'b1;
      end else if (deselected) begin
        bank_row_strobe_n_out <= 4'hF;
        col_strobe_n_out      <= 1'b1;
      end else begin
        mux_address_out <= (state == DAHR_COL || state == DAHR_CAS) ? col_latch : row_latch;
        for (int b = 0; b < 4; b++) begin
          bank_row_strobe_n_out[b] <= !((state == DAHR_ROW || state == DAHR_COL ||
                                        (state == DAHR_CAS && strobe_low)) && bank_latch == 2'(b)); // see RQ14
        end
        col_strobe_n_out <= !(state == DAHR_CAS); // see RQ2
      end
    end
  end

  // Open-drain flag pin: low for a forced request or the terminal count.
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      refresh_flag_pin_out    <= 1'b0;
      refresh_flag_pin_oe_out <= 1'b0;
    end else begin
      refresh_flag_pin_out    <= 1'b0;
      refresh_flag_pin_oe_out <= force_ask || (refresh_count == eoc_value); // see RQ10 RQ21
    end
  end

endmodule
`default_nettype wire

// ==== dahr_ctrl_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module dahr_ctrl_asserts
  import dahr_pkg::*;
(
  input wire logic       clock_in,
  input wire logic       srst_in,
  input wire logic [2:0] mode_in,
  input wire logic       chip_select_n_in,
  input wire logic       row_strobe_in,
  input wire logic       col_strobe_in,
  input wire logic       refresh_period_clock_in,
  input wire logic       mux_address_oe_out,
  input wire logic [3:0] bank_row_strobe_n_out,
  input wire logic       col_strobe_n_out,
  input wire logic       ctrl_oe_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);
  logic rf_q;
  logic done;
  always_ff @(posedge clock_in) begin
    rf_q <= refresh_period_clock_in;
  end
  // Cleared on the sampled rising edge, which the design sees no earlier.
  always_ff @(posedge clock_in) begin
    if (srst_in || (refresh_period_clock_in && !rf_q)) begin
      done <= 1'b0;
    end else if (mode_in == MODE_HIDDEN_AUTO && bank_row_strobe_n_out == 4'h0) begin
      done <= 1'b1;
    end
  end
  sequence s_acc_req;
    (mode_in == MODE_HIDDEN_AUTO || mode_in == MODE_FAST_AUTO) && !chip_select_n_in && $fell(row_strobe_in);
  endsequence
  sequence s_one_bank;
    ##[1:3] $countones(~bank_row_strobe_n_out) == 1;
  endsequence
  sequence s_bank_fall;
    $fell(&bank_row_strobe_n_out) && $countones(~bank_row_strobe_n_out) == 1;
  endsequence
  property p_acc; s_acc_req |-> s_one_bank; endproperty
  property p_hold; s_bank_fall |-> col_strobe_n_out ##[1:3] !col_strobe_n_out; endproperty
  property p_idle;
    (row_strobe_in && mode_in == MODE_HIDDEN_AUTO)[*4] |-> col_strobe_n_out && &bank_row_strobe_n_out;
  endproperty
  property p_ext; mode_in == MODE_FAST_AUTO && !col_strobe_in && !col_strobe_n_out |=> !col_strobe_n_out; endproperty
  property p_ext_end; (mode_in == MODE_FAST_AUTO && col_strobe_in && row_strobe_in)[*4] |-> col_strobe_n_out; endproperty
  property p_all;
    $fell(|bank_row_strobe_n_out) |-> $past(chip_select_n_in) || $past(mode_in) == MODE_FORCED_REFRESH;
  endproperty
  property p_once; $fell(|bank_row_strobe_n_out) && mode_in == MODE_HIDDEN_AUTO |-> !done; endproperty
  property p_desel; !ctrl_oe_out && $past(ctrl_oe_out) |-> $past(chip_select_n_in) && !mux_address_oe_out; endproperty
  property p_resel; $fell(chip_select_n_in) && !ctrl_oe_out |-> ##[1:2] ctrl_oe_out; endproperty
  a_acc: assert property (p_acc) else $error("bank strobe missing");
  a_hold: assert property (p_hold) else $error("column strobe timing");
  a_idle: assert property (p_idle) else $error("strobes not idle");
  a_ext: assert property (p_ext) else $error("column strobe not extended");
  a_ext_end: assert property (p_ext_end) else $error("column strobe stuck");
  a_all: assert property (p_all) else $error("all banks without refresh");
  a_once: assert property (p_once) else $error("second refresh in period");
  a_desel: assert property (p_desel) else $error("bad deselect");
  a_resel: assert property (p_resel) else $error("no reselect");
endmodule
bind dahr_ctrl dahr_ctrl_asserts dahr_ctrl_asserts_i (.clock_in(clock_in), .srst_in(srst_in),
  .mode_in(mode_in), .chip_select_n_in(chip_select_n_in), .row_strobe_in(row_strobe_in),
  .col_strobe_in(col_strobe_in), .refresh_period_clock_in(refresh_period_clock_in),
  .mux_address_oe_out(mux_address_oe_out), .bank_row_strobe_n_out(bank_row_strobe_n_out),
  .col_strobe_n_out(col_strobe_n_out), .ctrl_oe_out(ctrl_oe_out));
`default_nettype wire

// ==== dahr_dram.sv ====
`timescale 1ns/1ps
`default_nettype none
module dahr_dram (
  input  wire logic       clock_in,
  input  wire logic [8:0] addr_in,
  input  wire logic       addr_oe_in,
  input  wire logic [3:0] bank_n_in,
  input  wire logic       col_n_in,
  input  wire logic       we_n_in,
  output logic      [8:0] row_out,
  output logic      [8:0] col_out,
  output logic      [3:0] sel_out,
  output logic            wr_out
);
  logic [3:0] b_q = 4'hF;
  logic       c_q = 1'b1;
  // A released bus shows the inverse so a stale value cannot pass.
  wire logic [8:0] lvl = addr_oe_in ? addr_in : ~addr_in;
  always @(posedge clock_in) begin
    if (&b_q && !(&bank_n_in)) begin
      row_out <= lvl;
      sel_out <= ~bank_n_in;
    end
    if (c_q && !col_n_in) begin
      col_out <= lvl;
      wr_out <= !we_n_in;
    end
    b_q <= bank_n_in;
    c_q <= col_n_in;
  end
endmodule
`default_nettype wire

// ==== dahr_ctrl_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module dahr_ctrl_bench;
  import dahr_pkg::*;
  logic clk = 0, srst = 1, bh = 0, bl = 0, als = 0, cs_n = 0, rs_n = 1, cin_n = 1, wrq_n = 1, refresh_period_clock = 0;
  logic [2:0] mode = MODE_HIDDEN_AUTO;
  logic [8:0] ra = 9'h000, ca = 9'h000, q, p_row, p_col;
  logic [3:0] bank_n, p_sel;
  logic       q_oe, cas_n, we_n, c_oe, flag, flag_oe, p_wr;
  int         n_mismatch = 0, n_checks = 0;
  always #50 clk = ~clk;
  dahr_ctrl dahr_ctrl_i (.clock_in(clk), .srst_in(srst), .mode_in(mode), .row_addr_in(ra),
    .col_addr_in(ca), .bank_sel_hi_in(bh), .bank_sel_lo_in(bl), .address_latch_strobe_in(als),
    .chip_select_n_in(cs_n), .row_strobe_in(rs_n), .col_strobe_in(cin_n), .write_request_in(wrq_n),
    .refresh_period_clock_in(refresh_period_clock), .mux_address_out(q), .mux_address_oe_out(q_oe),
    .bank_row_strobe_n_out(bank_n), .col_strobe_n_out(cas_n), .write_strobe_n_out(we_n),
    .ctrl_oe_out(c_oe), .refresh_flag_pin_out(flag), .refresh_flag_pin_oe_out(flag_oe));
  dahr_dram dahr_dram_i (.clock_in(clk), .addr_in(q), .addr_oe_in(q_oe), .bank_n_in(bank_n),
    .col_n_in(cas_n), .we_n_in(we_n), .row_out(p_row), .col_out(p_col), .sel_out(p_sel), .wr_out(p_wr));
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic acc(input logic [2:0] m, input logic [1:0] b, input logic w);
    mode = m; ra = 9'h0A0 + b; ca = 9'h150 + b; {bh, bl} = b; als = 1; wrq_n = !w;
    tk(1);
    als = 0;
    tk(2);
    rs_n = 0;
    cin_n = (m != MODE_FAST_AUTO);
    for (int i = 0; i < 8 && cas_n !== 1'b0; i++) tk(1);
    rs_n = 1;
    tk(3);
    chk("bank_n", 9'h00F, bank_n);
    chk("col_ext", m != MODE_FAST_AUTO, cas_n);
    cin_n = 1;
    tk(3);
    chk("col_end", 1, cas_n);
    chk("row", ra, p_row);
    chk("col", ca, p_col);
    chk("sel", 4'h1 << b, p_sel);
    chk("write", w, p_wr);
  endtask
  task automatic hid(input logic [8:0] n);
    mode = MODE_HIDDEN_AUTO; refresh_period_clock = 1; tk(2);
    cs_n = 1; tk(2);
    rs_n = 0; tk(3);
    chk("ref_banks", 0, bank_n);
    chk("ref_row", n, p_row);
    rs_n = 1; tk(4);
    chk("ctrl_oe", 0, c_oe);
    chk("addr_oe", 0, q_oe);
    rs_n = 0; tk(3);
    chk("second_ref", 9'h00F, bank_n);
    rs_n = 1; tk(2);
    cs_n = 0; tk(3);
    chk("reselect", 1, c_oe);
    refresh_period_clock = 0; tk(3);
  endtask
  initial begin
    tk(20);
    srst = 0;
    tk(2);
    chk("flag_reset", 0, flag_oe);
    for (int b = 0; b < 4; b++) begin
      acc(MODE_HIDDEN_AUTO, 2'(b), b[0]);
      acc(MODE_FAST_AUTO, 2'(b), !b[0]);
    end
    for (int i = 0; i < 127; i++) hid(9'(i));
    chk("eoc_default", 1, flag_oe);
    chk("flag_level", 0, flag);
    // Counter sits at 127, so each selection shows directly on the flag.
    for (int k = 0; k < 4; k++) begin
      mode = MODE_SET_EOC; {bh, bl} = 2'(k ^ 1); als = 1; tk(1);
      als = 0; tk(3);
      chk("eoc_select", bh == bl, flag_oe);
    end
    // A request raised in hidden mode must be dropped by a pass through fast mode.
    mode = MODE_HIDDEN_AUTO; refresh_period_clock = 1; tk(3);
    mode = MODE_FAST_AUTO; tk(3);
    mode = MODE_HIDDEN_AUTO; tk(2);
    refresh_period_clock = 0; tk(3);
    chk("fast_flag", 0, flag_oe);
    mode = MODE_HIDDEN_AUTO; tk(2);
    refresh_period_clock = 1; tk(3);
    refresh_period_clock = 0; tk(3);
    chk("force_req", 1, flag_oe);
    mode = MODE_FORCED_REFRESH; tk(2);
    chk("force_banks", 0, bank_n);
    chk("force_row", 9'h07F, p_row);
    mode = MODE_HIDDEN_AUTO; tk(4);
    chk("force_clear", 0, flag_oe);
    end_sim;
  end
  initial begin
    #2000000;
    n_mismatch++;
    end_sim;
  end
endmodule
`default_nettype wire
